// *** dv/rsq_far_model.sv ***
// Model of the reset and request pins and of the stack and vector memory.
`timescale 1ns/1ps
module rsq_far_model (
  input  wire logic        core_clk,
  input  wire logic        rst_req,
  input  wire logic        irq_req,
  input  wire logic [15:0] mem_addr_q,
  input  wire logic        mem_wr_q,
  input  wire logic [7:0]  mem_wdata_q,
  output logic             reset_pin_n,
  output logic             irq_pin_n,
  output logic [7:0]       mem_rdata
);
  logic [7:0] ram [256];
  // The bench keeps a request for several cycles, well above the minimum low time.
  assign reset_pin_n = !rst_req;
  assign irq_pin_n   = !irq_req;
  // Vector bytes follow a fixed pattern so that every vector can be predicted.
  assign mem_rdata = (mem_addr_q >= 16'h1ff8) ? (mem_addr_q[7:0] ^ 8'h3c) : ram[mem_addr_q[7:0]];
  always_ff @(posedge core_clk) begin
    if (mem_wr_q) begin
      ram[mem_addr_q[7:0]] <= mem_wdata_q;
    end
  end
endmodule

// *** dv/rsq_seq_properties.sv ***
// Port checks for the reset and interrupt sequencer.
`timescale 1ns/1ps
module rsq_seq_properties
  import rsq_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 clk_en,
  input wire logic                 reset_pin_n,
  input wire logic                 insn_boundary,
  input wire logic                 swi_exec,
  input wire logic                 rti_exec,
  input wire logic [15:0]          pc_in,
  input wire logic [15:0]          bus_addr,
  input wire logic                 bus_wr,
  input wire logic [7:0]           rom_rdata,
  input wire logic                 cpu_reset_q,
  input wire logic                 ddr_clear_q,
  input wire logic                 timer_reset_q,
  input wire logic [7:0]           sp_q,
  input wire logic [7:0]           ccr_q,
  input wire logic [TMR_SRC_N-1:0] tmr_enables_q,
  input wire logic [15:0]          timer_preset_q,
  input wire logic                 stop_latch_q,
  input wire logic                 wait_latch_q,
  input wire logic                 seq_busy_q,
  input wire logic [15:0]          mem_addr_q,
  input wire logic                 mem_wr_q,
  input wire logic [7:0]           mem_wdata_q,
  input wire logic [7:0]           bus_rdata_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire [7:0] pc_lo  = pc_in[7:0];
  wire       swi_go = insn_boundary && swi_exec && clk_en && !seq_busy_q && !cpu_reset_q;
  wire       rti_go = insn_boundary && rti_exec && clk_en && !seq_busy_q && !cpu_reset_q;
  AST_RST_STATE: assert property (cpu_reset_q |-> sp_q == SP_RESET && ccr_q[CCR_I_BIT] && tmr_enables_q == 3'h0)
    else $error("reset state not held");
  AST_RST_SIDE: assert property (cpu_reset_q |-> ddr_clear_q && timer_reset_q && !stop_latch_q && !wait_latch_q)
    else $error("reset side effects missing");
  AST_PRESET: assert property (timer_preset_q == TIMER_PRESET)
    else $error("timer preset wrong");
  AST_PIN_RESET: assert property ((!reset_pin_n && clk_en) [*3] |-> ##[0:2] cpu_reset_q)
    else $error("pin low did not reset");
  AST_SWI_PCL: assert property (swi_go |=> mem_wr_q && mem_wdata_q == $past(pc_lo))
    else $error("first push is not pc low byte");
  AST_SWI_VEC: assert property (swi_go |-> ##[6:7] mem_addr_q == VEC_SWI_HI ##1 mem_addr_q == VEC_SWI_LO)
    else $error("trap vector order wrong");
  AST_SWI_DONE: assert property (swi_go |-> ##[8:10] (!seq_busy_q && ccr_q[CCR_I_BIT]))
    else $error("entry did not end masked");
  AST_RTI_PULL: assert property (rti_go |=> (seq_busy_q && !mem_wr_q) [*4])
    else $error("return wrote the stack");
  AST_WR_BUSY: assert property (mem_wr_q |-> seq_busy_q)
    else $error("stack write outside a sequence");
  AST_RDATA: assert property (bus_addr == WDOG_ADDR && !bus_wr && clk_en |=> bus_rdata_q == $past(rom_rdata))
    else $error("watchdog read not memory");
endmodule
bind rsq_sequencer rsq_seq_properties u_rsq_seq_properties (.*);

// *** dv/tb_top.sv ***
// Self-checking bench for the reset and interrupt sequencer.
`timescale 1ns/1ps
module tb_top;
  import rsq_pkg::*;
  logic        core_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, level_trigger = 1'b0, rst_req = 1'b0;
  logic        irq_req = 1'b0, insn_boundary = 1'b0, swi_exec = 1'b0, rti_exec = 1'b0, mask_clear = 1'b0;
  logic        mask_set = 1'b0, tmr_enable_wr = 1'b0, stop_exec = 1'b0, wait_exec = 1'b0, bus_wr = 1'b0;
  logic [2:0]  tmr_flags = 3'h0, tmr_enable_wr_data = 3'h0, tmr_enables_q;
  logic [7:0]  acc_in = 8'h00, idx_in = 8'h00, ccr_in = 8'h00, bus_wdata = 8'h00, rom_rdata = 8'h00;
  logic [15:0] pc_in = 16'h0000, bus_addr = 16'h0000, pc_q, timer_preset_q, mem_addr_q;
  logic        reset_pin_n, irq_pin_n, cpu_reset_q, ddr_clear_q, timer_reset_q, stop_latch_q;
  logic        wait_latch_q, seq_busy_q, mem_wr_q;
  logic [7:0]  mem_rdata, sp_q, ccr_q, acc_q, idx_q, mem_wdata_q, bus_rdata_q;
  logic [7:0]  pushq [$];
  logic [7:0]  exp5 [5];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n;

  rsq_sequencer u_rsq_sequencer (.*);
  rsq_far_model u_rsq_far_model (.*);

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (mem_wr_q === 1'b1) pushq.push_back(mem_wdata_q);

  function automatic logic [15:0] vec(input logic [7:0] a);
    return {a ^ 8'h3c, (a + 8'h01) ^ 8'h3c};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic wait_idle;
    n = 0;
    while ((seq_busy_q !== 1'b0 || cpu_reset_q !== 1'b0) && n < 6000) begin
      tick(1);
      n++;
    end
  endtask

  // One instruction boundary, then wait for any sequence it starts to finish.
  task automatic step(input logic software_trap, input logic return_from_trap);
    swi_exec = software_trap;
    rti_exec = return_from_trap;
    pulse(insn_boundary);
    swi_exec = 1'b0;
    rti_exec = 1'b0;
    tick(1);
    wait_idle();
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    tick(3);
    resetn = 1'b1;
    tick(2);
    chk({13'h0, cpu_reset_q, ddr_clear_q, timer_reset_q}, 16'h0007);
    chk({sp_q, ccr_q & 8'h08}, 16'hff08);
    chk({11'h0, tmr_enables_q, stop_latch_q, wait_latch_q}, 16'h0000);
    chk(timer_preset_q, TIMER_PRESET);
    n = 0;
    while (cpu_reset_q === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    chk(16'(n >= 4058 && n <= 4068), 16'h0001);
    wait_idle();
    chk(pc_q, vec(8'hfe));
    bus_addr = WDOG_ADDR;
    bus_wdata = 8'hfe;
    pulse(bus_wr);
    rom_rdata = 8'h96;
    tick(2);
    chk({8'h00, bus_rdata_q}, 16'h0096);
    tmr_enable_wr_data = 3'b010;
    pulse(tmr_enable_wr);
    tmr_flags = 3'b010;
    chk({13'h0, tmr_enables_q}, 16'h0002);
    step(1'b0, 1'b0);
    chk({sp_q, 8'(pushq.size())}, 16'hff00);
    pulse(mask_clear);
    irq_req = 1'b1;
    tick(4);
    pc_in = 16'h1234;
    acc_in = 8'ha1;
    idx_in = 8'hb2;
    step(1'b0, 1'b0);
    irq_req = 1'b0;
    chk(pc_q, vec(8'hfa));
    chk({sp_q, ccr_q & 8'h08}, 16'hfa08);
    exp5 = '{8'h34, 8'h12, 8'hb2, 8'ha1, 8'h00};
    for (int i = 0; i < 5; i++) chk({8'h00, pushq[i]}, {8'h00, exp5[i]});
    step(1'b0, 1'b1);
    chk(pc_q, 16'h1234);
    chk({acc_q, idx_q}, 16'ha1b2);
    chk({ccr_q, sp_q}, 16'h00ff);
    pc_in = 16'h5678;
    step(1'b0, 1'b0);
    chk(pc_q, vec(8'hf8));
    tmr_flags = 3'h0;
    step(1'b1, 1'b0);
    chk(pc_q, vec(8'hfc));
    chk({8'h00, sp_q}, 16'h00f5);
    // An edge seen while masked must stay latched until the mask clears.
    irq_req = 1'b1;
    tick(4);
    irq_req = 1'b0;
    step(1'b0, 1'b0);
    chk({8'h00, sp_q}, 16'h00f5);
    step(1'b0, 1'b0);
    chk({pc_q[7:0], sp_q}, 16'hc7f0);
    // With level triggering a pin held low re-enters after the latch clears.
    level_trigger = 1'b1;
    irq_req = 1'b1;
    tick(4);
    repeat (2) step(1'b0, 1'b0);
    chk({8'h00, sp_q}, 16'h00eb);
    repeat (2) step(1'b0, 1'b0);
    chk({8'h00, sp_q}, 16'h00e6);
    irq_req = 1'b0;
    level_trigger = 1'b0;
    // A boundary offered while the clock enable is low must be ignored.
    clk_en = 1'b0;
    step(1'b1, 1'b0);
    clk_en = 1'b1;
    tick(1);
    chk({seq_busy_q, 7'h00, sp_q}, 16'h00e6);
    pulse(stop_exec);
    pulse(wait_exec);
    rst_req = 1'b1;
    tick(4);
    chk({cpu_reset_q, stop_latch_q, wait_latch_q, 5'h0, sp_q}, 16'h80ff);
    rst_req = 1'b0;
    wait_idle();
    chk(pc_q, vec(8'hfe));
    give_verdict();
  end

  initial begin
    #(20000 * 100);
    n_mismatch++;
    give_verdict();
  end
endmodule

// *** logic/rsq_irq_arb.sv ***
// External request latch and interrupt priority selection.
`timescale 1ns/1ps
module rsq_irq_arb
  import rsq_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic                 irq_pin_n,
  input  wire logic                 level_trigger,
  input  wire logic                 ext_latch_clear,
  input  wire logic [TMR_SRC_N-1:0] tmr_flags,
  input  wire logic [TMR_SRC_N-1:0] tmr_enables,
  input  wire logic                 int_mask,
  output rsq_src_e                  pend_src
);
  logic [1:0]           irq_sync_q;
  logic                 irq_prev_q;
  logic                 ext_latch_q;
  logic                 ext_pend;
  logic                 tmr_pend;
  logic [TMR_SRC_N-1:0] tmr_hit;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_sync_q <= '1;
      irq_prev_q <= 1'b1;
    end else if (clk_en) begin
      irq_sync_q <= {irq_sync_q[0], irq_pin_n};
      irq_prev_q <= irq_sync_q[1];
    end
  end

  // A new falling edge wins over the clear made by the vector fetch.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ext_latch_q <= 1'b0;
    end else if (clk_en) begin
      if (irq_prev_q && !irq_sync_q[1]) begin
        ext_latch_q <= 1'b1; // see RL21
      end else if (ext_latch_clear) begin
        ext_latch_q <= 1'b0; // see RL21
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < TMR_SRC_N; g++) begin : g_tmr
      assign tmr_hit[g] = tmr_flags[g] & tmr_enables[g]; // see RL15
    end
  endgenerate

  assign ext_pend = ext_latch_q || (level_trigger && !irq_sync_q[1]); // see RL22
  assign tmr_pend = |tmr_hit;

  always_comb begin
    pend_src = RSQ_SRC_NONE;
    if (!int_mask) begin
      if (ext_pend) begin
        pend_src = RSQ_SRC_EXT; // see RL14 see RL18
      end else if (tmr_pend) begin
        pend_src = RSQ_SRC_TMR; // see RL15
      end
    end
  end
endmodule

// *** logic/rsq_pkg.sv ***
// Package of constants for the reset and interrupt sequencer.
package rsq_pkg;
  localparam int          POR_DELAY_CYC    = 4064;
  localparam int          POR_CNT_W        = 12;
  localparam int          WDOG_STAGES      = 18;
  localparam logic [15:0] WDOG_ADDR        = 16'h1ff0;
  localparam int          WDOG_CLR_BIT     = 0;
  localparam logic [7:0]  SP_RESET         = 8'hff;
  localparam logic [15:0] TIMER_PRESET     = 16'hfffc;
  localparam logic [15:0] VEC_RESET_HI     = 16'h1ffe;
  localparam logic [15:0] VEC_RESET_LO     = 16'h1fff;
  localparam logic [15:0] VEC_SWI_HI       = 16'h1ffc;
  localparam logic [15:0] VEC_SWI_LO       = 16'h1ffd;
  localparam logic [15:0] VEC_EXT_HI       = 16'h1ffa;
  localparam logic [15:0] VEC_EXT_LO       = 16'h1ffb;
  localparam logic [15:0] VEC_TMR_HI       = 16'h1ff8;
  localparam logic [15:0] VEC_TMR_LO       = 16'h1ff9;
  localparam int          TMR_SRC_N        = 3;
  localparam int          CCR_I_BIT        = 3;

  typedef enum logic [2:0] {
    RSQ_SRC_NONE,
    RSQ_SRC_EXT,
    RSQ_SRC_TMR,
    RSQ_SRC_SWI
  } rsq_src_e;

  typedef enum logic [3:0] {
    RSQ_ST_RESET,
    RSQ_ST_VEC_HI,
    RSQ_ST_VEC_LO,
    RSQ_ST_RUN,
    RSQ_ST_PUSH_PCL,
    RSQ_ST_PUSH_PCH,
    RSQ_ST_PUSH_X,
    RSQ_ST_PUSH_A,
    RSQ_ST_PUSH_CC,
    RSQ_ST_PULL_CC,
    RSQ_ST_PULL_A,
    RSQ_ST_PULL_X,
    RSQ_ST_PULL_PCH,
    RSQ_ST_PULL_PCL
  } rsq_state_e;
endpackage

// *** logic/rsq_reset_gen.sv ***
// Reset source combiner: power-on delay, pin reset and watchdog.
`timescale 1ns/1ps
module rsq_reset_gen
  import rsq_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic reset_pin_n,
  input  wire logic wdog_clear,
  output logic      cpu_reset_q
);
  logic [1:0]           pin_sync_q;
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic                 por_done_q;
  logic [WDOG_STAGES-1:0] wdog_q;
  logic                 wdog_expire;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_sync_q <= '1;
    end else if (clk_en) begin
      pin_sync_q <= {pin_sync_q[0], reset_pin_n};
    end
  end

  // Power-on hold; resetn stands for the supply ramp.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
    end else if (clk_en && !por_done_q) begin
      por_cnt_q <= por_cnt_q + 1'b1;
      if (por_cnt_q == POR_CNT_W'(POR_DELAY_CYC - 1)) begin
        por_done_q <= 1'b1; // see RL7
      end
    end
  end

  assign wdog_expire = &wdog_q;

  // The counter does not run during reset; it is cleared while reset is held.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdog_q <= '0;
    end else if (clk_en) begin
      if (wdog_clear || cpu_reset_q) begin
        wdog_q <= '0; // see RL11
      end else begin
        wdog_q <= wdog_q + 1'b1; // see RL10
      end
    end
  end

  // A low pin holds reset beyond the power-on delay.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cpu_reset_q <= 1'b1;
    end else if (clk_en) begin
      cpu_reset_q <= !por_done_q || !pin_sync_q[1] || wdog_expire; // see RL7 see RL8 see RL10
    end
  end
endmodule

// *** logic/rsq_sequencer.sv ***
// Reset and interrupt sequencer for a small 8-bit core.
// Overview of operation
// (RL1) Any reset aborts current instruction immediately.
// (RL2) Reset clears all port direction bits.
// (RL3) Reset sets stack pointer FF, mask set.
// (RL4) Reset clears timer divider, presets counter, enables.
// (RL5) Reset clears stop and wait latches.
// (RL6) Reset vector fetched from top two bytes.
// (RL7) Power-on holds reset, extended by low pin.
// (RL8) Pin low one and half cycles resets.
// (RL9) Reset pin is never driven by device.
// (RL10) Eighteen-stage watchdog expiry resets whole device.
// (RL11) Writing zero to clear bit restarts watchdog.
// (RL12) Watchdog register reads return memory contents.
// (RL13) Requests checked only at instruction boundaries.
// (RL14) External request recognised when mask clear.
// (RL15) Enabled timer flags request when mask clear.
// (RL16) Entry pushes PC low, high, X, A, CC.
// (RL17) Return pulls CC, A, X, PC high, low.
// (RL18) External interrupt beats timer interrupt.
// (RL19) External vector at 1FFA and 1FFB.
// (RL20) Software trap ignores mask, own vector.
// (RL21) Latch clears at vector fetch, relatches later.
// (RL22) Trigger mode selectable; timers share vector.
`timescale 1ns/1ps
module rsq_sequencer
  import rsq_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic                 reset_pin_n,
  input  wire logic                 irq_pin_n,
  input  wire logic                 level_trigger,
  input  wire logic [TMR_SRC_N-1:0] tmr_flags,
  input  wire logic                 insn_boundary,
  input  wire logic                 swi_exec,
  input  wire logic                 rti_exec,
  input  wire logic                 mask_clear,
  input  wire logic                 mask_set,
  input  wire logic [TMR_SRC_N-1:0] tmr_enable_wr_data,
  input  wire logic                 tmr_enable_wr,
  input  wire logic [7:0]           acc_in,
  input  wire logic [7:0]           idx_in,
  input  wire logic [7:0]           ccr_in,
  input  wire logic [15:0]          pc_in,
  input  wire logic                 stop_exec,
  input  wire logic                 wait_exec,
  input  wire logic [15:0]          bus_addr,
  input  wire logic                 bus_wr,
  input  wire logic [7:0]           bus_wdata,
  input  wire logic [7:0]           rom_rdata,
  input  wire logic [7:0]           mem_rdata,
  output logic                      cpu_reset_q,
  output logic                      ddr_clear_q,
  output logic                      timer_reset_q,
  output logic [7:0]                sp_q,
  output logic [7:0]                ccr_q,
  output logic [7:0]                acc_q,
  output logic [7:0]                idx_q,
  output logic [15:0]               pc_q,
  output logic [TMR_SRC_N-1:0]      tmr_enables_q,
  output logic [15:0]               timer_preset_q,
  output logic                      stop_latch_q,
  output logic                      wait_latch_q,
  output logic                      seq_busy_q,
  output logic [15:0]               mem_addr_q,
  output logic                      mem_wr_q,
  output logic [7:0]                mem_wdata_q,
  output logic [7:0]                bus_rdata_q
);
  rsq_state_e state_q;
  rsq_src_e   pend_src;
  rsq_src_e   take_src_q;
  logic       rst_int;
  logic       wdog_clear;
  logic       ext_latch_clear;
  logic [15:0] vec_hi;
  logic [15:0] vec_lo;

  // The reset pin is sampled only; nothing here can drive it.
  assign wdog_clear = bus_wr && (bus_addr == WDOG_ADDR) && !bus_wdata[WDOG_CLR_BIT]; // see RL9 see RL11

  rsq_reset_gen u_reset (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .clk_en     (clk_en),
    .reset_pin_n(reset_pin_n),
    .wdog_clear (wdog_clear),
    .cpu_reset_q(rst_int)
  );

  assign ext_latch_clear = (state_q == RSQ_ST_VEC_HI) && (take_src_q == RSQ_SRC_EXT); // see RL21

  rsq_irq_arb u_arb (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .clk_en         (clk_en),
    .irq_pin_n      (irq_pin_n),
    .level_trigger  (level_trigger),
    .ext_latch_clear(ext_latch_clear),
    .tmr_flags      (tmr_flags),
    .tmr_enables    (tmr_enables_q),
    .int_mask       (ccr_q[CCR_I_BIT]),
    .pend_src       (pend_src)
  );

  always_comb begin
    case (take_src_q)
      RSQ_SRC_EXT: begin
        vec_hi = VEC_EXT_HI; // see RL19
        vec_lo = VEC_EXT_LO;
      end
      RSQ_SRC_SWI: begin
        vec_hi = VEC_SWI_HI; // see RL20
        vec_lo = VEC_SWI_LO;
      end
      RSQ_SRC_TMR: begin
        vec_hi = VEC_TMR_HI; // see RL22
        vec_lo = VEC_TMR_LO;
      end
      default: begin
        vec_hi = VEC_RESET_HI; // see RL6
        vec_lo = VEC_RESET_LO;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cpu_reset_q   <= 1'b1;
      ddr_clear_q   <= 1'b1;
      timer_reset_q <= 1'b1;
    end else if (clk_en) begin
      cpu_reset_q   <= rst_int; // see RL1
      ddr_clear_q   <= rst_int; // see RL2
      timer_reset_q <= rst_int; // see RL4
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      timer_preset_q <= TIMER_PRESET;
      tmr_enables_q  <= '0;
    end else if (clk_en) begin
      timer_preset_q <= TIMER_PRESET;
      if (rst_int) begin
        tmr_enables_q <= '0; // see RL4
      end else if (tmr_enable_wr) begin
        tmr_enables_q <= tmr_enable_wr_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stop_latch_q <= 1'b0;
      wait_latch_q <= 1'b0;
    end else if (clk_en) begin
      if (rst_int) begin
        stop_latch_q <= 1'b0; // see RL5
        wait_latch_q <= 1'b0; // see RL5
      end else begin
        if (stop_exec) begin
          stop_latch_q <= 1'b1;
        end
        if (wait_exec) begin
          wait_latch_q <= 1'b1;
        end else if (pend_src != RSQ_SRC_NONE) begin
          wait_latch_q <= 1'b0;
        end
      end
    end
  end

  // Watchdog address is write-only; reads see the memory beneath it.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus_rdata_q <= '0;
    end else if (clk_en) begin
      bus_rdata_q <= rom_rdata; // see RL12
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q     <= RSQ_ST_RESET;
      take_src_q  <= RSQ_SRC_NONE;
      sp_q        <= SP_RESET;
      ccr_q       <= 8'(1 << CCR_I_BIT); // see RL3
      acc_q       <= '0;
      idx_q       <= '0;
      pc_q        <= '0;
      mem_addr_q  <= '0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= '0;
      seq_busy_q  <= 1'b1;
    end else if (clk_en) begin
      mem_wr_q <= 1'b0;
      if (rst_int) begin
        // Abort whatever step was running; no stack write survives.
        state_q    <= RSQ_ST_RESET; // see RL1
        take_src_q <= RSQ_SRC_NONE;
        sp_q       <= SP_RESET; // see RL3
        ccr_q[CCR_I_BIT] <= 1'b1; // see RL3
        seq_busy_q <= 1'b1;
      end else begin
        case (state_q)
          RSQ_ST_RESET: begin
            mem_addr_q <= vec_hi;
            state_q    <= RSQ_ST_VEC_HI;
          end
          RSQ_ST_VEC_HI: begin
            pc_q[15:8] <= mem_rdata;
            mem_addr_q <= vec_lo;
            state_q    <= RSQ_ST_VEC_LO;
          end
          RSQ_ST_VEC_LO: begin
            pc_q[7:0]  <= mem_rdata;
            seq_busy_q <= 1'b0;
            state_q    <= RSQ_ST_RUN;
          end
          RSQ_ST_RUN: begin
            if (mask_set) begin
              ccr_q[CCR_I_BIT] <= 1'b1;
            end else if (mask_clear) begin
              ccr_q[CCR_I_BIT] <= 1'b0;
            end
            if (insn_boundary) begin // see RL13
              pc_q  <= pc_in;
              acc_q <= acc_in;
              idx_q <= idx_in;
              ccr_q <= ccr_in;
              if (rti_exec) begin
                seq_busy_q <= 1'b1;
                sp_q       <= sp_q + 8'h01;
                mem_addr_q <= {8'h00, sp_q + 8'h01};
                state_q    <= RSQ_ST_PULL_CC; // see RL17
              end else if (swi_exec || pend_src != RSQ_SRC_NONE) begin
                take_src_q  <= swi_exec ? RSQ_SRC_SWI : pend_src; // see RL20
                seq_busy_q  <= 1'b1;
                mem_addr_q  <= {8'h00, sp_q};
                mem_wdata_q <= pc_in[7:0];
                mem_wr_q    <= 1'b1;
                sp_q        <= sp_q - 8'h01;
                state_q     <= RSQ_ST_PUSH_PCH; // see RL16
              end
            end
          end
          RSQ_ST_PUSH_PCH, RSQ_ST_PUSH_X, RSQ_ST_PUSH_A, RSQ_ST_PUSH_CC: begin
            mem_addr_q <= {8'h00, sp_q};
            mem_wr_q   <= 1'b1;
            sp_q       <= sp_q - 8'h01;
            case (state_q)
              RSQ_ST_PUSH_PCH: begin
                mem_wdata_q <= pc_q[15:8];
                state_q     <= RSQ_ST_PUSH_X;
              end
              RSQ_ST_PUSH_X: begin
                mem_wdata_q <= idx_q;
                state_q     <= RSQ_ST_PUSH_A;
              end
              RSQ_ST_PUSH_A: begin
                mem_wdata_q <= acc_q;
                state_q     <= RSQ_ST_PUSH_CC;
              end
              default: begin
                mem_wdata_q      <= ccr_q;
                ccr_q[CCR_I_BIT] <= 1'b1; // see RL16
                state_q          <= RSQ_ST_PUSH_PCL;
              end
            endcase
          end
          RSQ_ST_PUSH_PCL: begin
            mem_addr_q <= vec_hi;
            state_q    <= RSQ_ST_VEC_HI;
          end
          RSQ_ST_PULL_CC, RSQ_ST_PULL_A, RSQ_ST_PULL_X, RSQ_ST_PULL_PCH: begin
            sp_q       <= sp_q + 8'h01;
            mem_addr_q <= {8'h00, sp_q + 8'h01};
            case (state_q)
              RSQ_ST_PULL_CC: begin
                ccr_q   <= mem_rdata;
                state_q <= RSQ_ST_PULL_A;
              end
              RSQ_ST_PULL_A: begin
                acc_q   <= mem_rdata;
                state_q <= RSQ_ST_PULL_X;
              end
              RSQ_ST_PULL_X: begin
                idx_q   <= mem_rdata;
                state_q <= RSQ_ST_PULL_PCH;
              end
              default: begin
                pc_q[15:8] <= mem_rdata;
                state_q    <= RSQ_ST_PULL_PCL;
              end
            endcase
          end
          RSQ_ST_PULL_PCL: begin
            pc_q[7:0]  <= mem_rdata; // see RL17
            seq_busy_q <= 1'b0;
            state_q    <= RSQ_ST_RUN;
          end
          default: begin
            state_q <= RSQ_ST_RESET;
          end
        endcase
      end
    end
  end
endmodule
